// [src/mms_pkg.sv]
// Shared constants and types for the magnetometer mode sequencer
package mms_pkg;

    // Timing in ns, converted to cycles of the 100 MHz clock
    localparam int unsigned CLK_NS       = 10;
    localparam int unsigned SETTLE_NS    = 250000;
    localparam int unsigned ACT_NS       = 8000;
    localparam int unsigned STROBE_NS    = 10000;
    localparam int unsigned TICK_NS      = 1000000;
    localparam int unsigned SETTLE_CYC_D = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned ACT_CYC      = (ACT_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned TICK_CYC_D   = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam int unsigned STB_W        = 10;
    localparam logic [STB_W-1:0] STROBE_CYC =
        STB_W'((STROBE_NS + CLK_NS - 1) / CLK_NS);

    // Register offsets and fields
    localparam logic [7:0] REG_RATE = 8'h01;
    localparam logic [7:0] REG_CFG  = 8'h02;
    localparam logic [7:0] REG_THR  = 8'h03;
    localparam int unsigned RATE_W  = 7;
    localparam int unsigned SEL_LSB = 0;
    localparam int unsigned REF_BIT = 4;
    localparam int unsigned TRG_BIT = 5;
    localparam int unsigned FW_BIT  = 6;
    localparam logic [RATE_W-1:0] RATE_RST = 7'h13;
    localparam logic [3:0]  SEL_RST = 4'h7;
    localparam logic [15:0] THR_RST = 16'h0010;

    typedef enum logic [2:0] {
        OP_NOP    = 3'h0,
        OP_WRITE  = 3'h1,
        OP_READ   = 3'h2,
        OP_SINGLE = 3'h3,
        OP_BURST  = 3'h4,
        OP_WOC    = 3'h5,
        OP_EXIT   = 3'h6,
        OP_RESET  = 3'h7
    } mms_op_t;

    typedef enum logic [1:0] {
        MODE_SINGLE = 2'h0,
        MODE_BURST  = 2'h1,
        MODE_WOC    = 2'h2
    } mms_mode_t;

    typedef enum logic [5:0] {
        ST_IDLE   = 6'h01,
        ST_SETTLE = 6'h02,
        ST_ACT    = 6'h04,
        ST_CONV   = 6'h08,
        ST_STANDBY_STATE   = 6'h10,
        ST_WSLP   = 6'h20
    } mms_state_t;

    typedef struct packed {
        mms_op_t     op;
        logic [7:0]  addr;
        logic [15:0] data;
    } mms_cmd_t;

    typedef struct packed {
        mms_mode_t  mode;
        mms_state_t state;
        logic       ready;
        logic       ref_valid;
    } mms_status_t;

endpackage

// [src/mms_seq.sv]
// Measurement-mode sequencer with data-ready pin and strap capture
module mms_seq
    import mms_pkg::*;
#(
    parameter int unsigned SETTLE_CYC = SETTLE_CYC_D,
    parameter int unsigned TICK_CYC   = TICK_CYC_D
) (
    // System clock and reset
    input  wire logic        clk,
    input  wire logic        rst_n,
    // Command link from the serial front end
    input  wire logic        link_clk,
    input  wire logic        link_cmd_valid,
    input  wire mms_cmd_t    link_cmd,
    // Straps
    input  wire logic        interface_select_strap,
    input  wire logic        addr_strap_low,
    input  wire logic        addr_strap_high,
    // Shared ready / trigger pin
    input  wire logic        ready_flag_pin_in,
    output logic             ready_flag_pin_out,
    output logic             ready_flag_pin_oe,
    // Converter
    output logic             adc_start,
    output logic [1:0]       adc_chan,
    input  wire logic        adc_done,
    input  wire logic [15:0] adc_value,
    // Port setup and status
    output logic             i2c_mode,
    output logic [1:0]       i2c_addr_bits,
    output logic             serial_out_en,
    output mms_status_t      status
);

    ////////////////////////////////////////////////////////////////////
    // Link domain: hold the command and flip a toggle per command
    logic [1:0] lrst_q;
    logic       tgl_q;
    mms_cmd_t   hold_q;

    // Reset brought into the link domain
    always_ff @(posedge link_clk) begin
        lrst_q <= {lrst_q[0], rst_n};
    end

    // Hold stays put until the next command, so clk may read it later
    always_ff @(posedge link_clk) begin
        if (!lrst_q[1]) begin
            tgl_q  <= 1'b0;
            hold_q <= '0;
        end else if (link_cmd_valid) begin
            hold_q <= link_cmd;
            tgl_q  <= ~tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Clock domain: toggle sync, strap and trigger synchronisers
    logic [2:0] tsync_q;
    logic [2:0] trg_q;
    logic [2:0] strap1_q;
    logic [2:0] strap2_q;
    logic       strap_done_q;

    always_ff @(posedge clk) begin
        tsync_q  <= {tsync_q[1:0], tgl_q};
        trg_q    <= {trg_q[1:0], ready_flag_pin_in};
        strap1_q <= {interface_select_strap, addr_strap_high,
                     addr_strap_low};
        strap2_q <= strap1_q;
    end
    logic cmd_ev;
    logic wr_cmd, rd_cmd, sgl_cmd, bst_cmd, woc_cmd, ex_cmd, rt_cmd;
    assign cmd_ev  = tsync_q[2] ^ tsync_q[1];
    assign wr_cmd  = cmd_ev && hold_q.op == OP_WRITE;
    assign rd_cmd  = cmd_ev && hold_q.op == OP_READ;
    assign sgl_cmd = cmd_ev && hold_q.op == OP_SINGLE;
    assign bst_cmd = cmd_ev && hold_q.op == OP_BURST;
    assign woc_cmd = cmd_ev && hold_q.op == OP_WOC;
    assign ex_cmd  = cmd_ev && hold_q.op == OP_EXIT;
    assign rt_cmd  = cmd_ev && hold_q.op == OP_RESET;
    // Straps caught once, first cycle after reset release
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_done_q  <= 1'b0;
            i2c_mode      <= 1'b0;
            i2c_addr_bits <= 2'h0;
        end else if (!strap_done_q) begin
            strap_done_q  <= 1'b1;
            i2c_mode      <= strap2_q[2];
            i2c_addr_bits <= strap2_q[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Configuration registers
    logic [RATE_W-1:0] rate_q;
    logic [3:0]        sel_q;
    logic              ref_prev_q;
    logic              trig_en_q;
    logic              four_wire_q;
    logic [15:0]       thr_q;

    // Reset command restores defaults like power-on
    always_ff @(posedge clk) begin
        if (!rst_n || rt_cmd) begin
            rate_q      <= RATE_RST;
            sel_q       <= SEL_RST;
            ref_prev_q  <= 1'b0;
            trig_en_q   <= 1'b0;
            four_wire_q <= 1'b0;
            thr_q       <= THR_RST;
        end else if (wr_cmd) begin
            if (hold_q.addr == REG_RATE)
                rate_q <= hold_q.data[RATE_W-1:0];
            if (hold_q.addr == REG_CFG) begin
                sel_q       <= hold_q.data[SEL_LSB +: 4];
                ref_prev_q  <= hold_q.data[REF_BIT];
                trig_en_q   <= hold_q.data[TRG_BIT];
                four_wire_q <= hold_q.data[FW_BIT];
            end
            if (hold_q.addr == REG_THR)
                thr_q <= hold_q.data;
        end
    end

    // Output pin of four-wire SPI only
    always_ff @(posedge clk) begin
        if (!rst_n)
            serial_out_en <= 1'b0;
        else
            serial_out_en <= !i2c_mode && four_wire_q;
    end

    ////////////////////////////////////////////////////////////////////
    // Helper functions
    // Next enabled item at or above 'from'; {found, index}
    function automatic logic [2:0] next_en(input logic [3:0] sel,
                                           input logic [2:0] from);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 3; i >= 0; i--) begin
            if (sel[i] && 3'(i) >= from)
                r = {1'b1, 2'(i)};
        end
        return r;
    endfunction

    // Magnitude of difference between two signed results
    function automatic logic [16:0] abs_diff(input logic [15:0] a,
                                             input logic [15:0] b);
        logic signed [16:0] d;
        d = $signed({a[15], a}) - $signed({b[15], b});
        return d[16] ? 17'(-d) : 17'(d);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // Mode and sequencing state
    mms_mode_t  mode_q;
    mms_state_t state_q, nxt;
    logic [31:0] ph_q;
    logic [31:0] ivl_q;
    logic [31:0] ivl_cyc;
    logic        go_idle, start_meas, trig_go, set_done, more, ivl_done;
    logic [2:0]  nx_first, nx_more;
    // Gated so a pulse mid-sequence is dropped
    assign trig_go = trg_q[1] && !trg_q[2] && trig_en_q
                     && mode_q == MODE_SINGLE && state_q == ST_IDLE;
    assign go_idle = rt_cmd || ex_cmd ||
                     (sgl_cmd && mode_q != MODE_SINGLE);
    assign start_meas = sgl_cmd || trig_go ||
                        ((bst_cmd || woc_cmd) &&
                         mode_q == MODE_SINGLE);
    assign ivl_cyc  = 32'(({25'h0, rate_q} + 32'h1) * TICK_CYC);
    assign ivl_done = ivl_q >= ivl_cyc - 32'h1;
    assign nx_first = next_en(sel_q, 3'h0);
    assign nx_more  = next_en(sel_q, 3'({1'b0, adc_chan} + 3'h1));
    assign more     = nx_more[2];
    assign set_done = state_q == ST_CONV &&
                      (sel_q == 4'h0 || (adc_done && !more));
    // Mode register; power-up is single mode
    always_ff @(posedge clk) begin
        if (!rst_n || rt_cmd || ex_cmd || sgl_cmd)
            mode_q <= MODE_SINGLE;
        else if (bst_cmd)
            mode_q <= MODE_BURST;
        else if (woc_cmd)
            mode_q <= MODE_WOC;
    end

    // Next state
    always_comb begin
        nxt = state_q;
        if (go_idle) begin
            nxt = ST_IDLE;
        end else begin
            unique case (state_q)
                ST_IDLE:   if (start_meas) nxt = ST_SETTLE;
                ST_SETTLE: if (ph_q == SETTLE_CYC - 1) nxt = ST_ACT;
                ST_ACT:    if (ph_q == ACT_CYC - 1) nxt = ST_CONV;
                ST_CONV: begin
                    if (set_done)
                        nxt = (mode_q == MODE_BURST) ? ST_STANDBY_STATE :
                              (mode_q == MODE_WOC)   ? ST_WSLP : ST_IDLE;
                end
                ST_STANDBY_STATE:   if (ivl_done) nxt = ST_ACT;
                ST_WSLP:   if (ivl_done) nxt = ST_SETTLE;
                default:   nxt = ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n)
            state_q <= ST_IDLE;
        else
            state_q <= nxt;
    end

    // Phase timer restarts on every state change
    always_ff @(posedge clk) begin
        if (!rst_n || nxt != state_q)
            ph_q <= 32'h0;
        else
            ph_q <= ph_q + 32'h1;
    end

    // Interval timer spans a whole cycle, so the rate never outruns
    // the conversions themselves
    always_ff @(posedge clk) begin
        if (!rst_n || state_q == ST_IDLE ||
            (state_q == ST_STANDBY_STATE && nxt == ST_ACT) ||
            (state_q == ST_WSLP && nxt == ST_SETTLE))
            ivl_q <= 32'h0;
        else if (!ivl_done)
            ivl_q <= ivl_q + 32'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // Converter control, order Z, Y, X, temperature
    logic [15:0] res_q [4];
    logic [15:0] ref_q [4];
    logic        ref_ok_q;
    logic        done_q;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            adc_start <= 1'b0;
            adc_chan  <= 2'h0;
        end else begin
            adc_start <= 1'b0;
            if (nxt == ST_CONV && state_q != ST_CONV && nx_first[2]) begin
                adc_start <= 1'b1;
                adc_chan  <= nx_first[1:0];
            end else if (nxt == ST_CONV && adc_done && more) begin
                adc_start <= 1'b1;
                adc_chan  <= nx_more[1:0];
            end
        end
    end

    // Results; compared one cycle after the set ends
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            res_q  <= '{default: 16'h0};
            done_q <= 1'b0;
        end else begin
            done_q <= set_done && !go_idle;
            if (state_q == ST_CONV && adc_done)
                res_q[adc_chan] <= adc_value;
        end
    end

    // Change detection on monitored items
    logic hit;
    always_comb begin
        hit = 1'b0;
        for (int i = 0; i < 4; i++) begin
            if (sel_q[i] && abs_diff(res_q[i], ref_q[i]) > {1'b0, thr_q})
                hit = 1'b1;
        end
        hit = hit && ref_ok_q;
    end

    // Reference: first set once, or always the previous set
    always_ff @(posedge clk) begin
        if (!rst_n || mode_q != MODE_WOC) begin
            ref_q    <= '{default: 16'h0};
            ref_ok_q <= 1'b0;
        end else if (done_q && (!ref_ok_q || ref_prev_q)) begin
            ref_q    <= res_q;
            ref_ok_q <= 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Data-ready flag, strobe and pin
    logic             flag_ev, clr, ready_q;
    logic [STB_W-1:0] stb_q;
    assign flag_ev = done_q && (mode_q != MODE_WOC || hit);
    assign clr     = rd_cmd || ex_cmd || rt_cmd;
    // A new set in the clearing cycle still sets the flag
    always_ff @(posedge clk) begin
        if (!rst_n)
            ready_q <= 1'b0;
        else if (flag_ev)
            ready_q <= 1'b1;
        else if (clr)
            ready_q <= 1'b0;
    end

    // Unread previous set outside single mode: drop the pin so the next rise marks new data
    always_ff @(posedge clk) begin
        if (!rst_n || rt_cmd || ex_cmd)
            stb_q <= '0;
        else if (flag_ev && ready_q && !clr && mode_q != MODE_SINGLE)
            stb_q <= STROBE_CYC;
        else if (stb_q != '0)
            stb_q <= stb_q - 1'b1;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ready_flag_pin_out <= 1'b0;
            ready_flag_pin_oe  <= 1'b1;
            status             <= '0;
        end else begin
            ready_flag_pin_out <= ready_q && stb_q == '0;
            ready_flag_pin_oe  <= !(trig_en_q &&
                                    mode_q == MODE_SINGLE);
            status <= '{mode: mode_q, state: state_q, ready: ready_q,
                        ref_valid: ref_ok_q};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    settle_len_a: assert property (state_q == ST_SETTLE && nxt == ST_ACT
        |-> ph_q == SETTLE_CYC - 1)
        else $error("settling delay wrong length");
    act_len_a: assert property (state_q == ST_ACT && !go_idle
        && nxt == ST_CONV |-> ph_q == ACT_CYC - 1)
        else $error("activation delay wrong length");
    burst_skip_a: assert property (state_q == ST_STANDBY_STATE && nxt != ST_STANDBY_STATE
        && !go_idle |-> nxt == ST_ACT)
        else $error("burst cycle did not skip settling");
    ready_hold_a: assert property (ready_q && !clr |=> ready_q)
        else $error("ready dropped without a clear");
    strobe_low_a: assert property (flag_ev && ready_q && !clr && !go_idle
        && mode_q != MODE_SINGLE |-> ##2 !ready_flag_pin_out [*8])
        else $error("ready pin not strobed low");
    single_ret_a: assert property (mode_q == MODE_SINGLE && set_done
        && !go_idle && !bst_cmd && !woc_cmd |=> state_q == ST_IDLE)
        else $error("single set did not return to idle");
    woc_quiet_a: assert property (done_q && mode_q == MODE_WOC && !hit
        && !ready_q |=> !ready_q)
        else $error("ready raised without a change");
    conv_order_a: assert property (adc_start && $past(state_q) == ST_CONV
        |-> adc_chan > $past(adc_chan))
        else $error("conversion order broken");
    trig_gate_a: assert property (state_q == ST_IDLE && !cmd_ev
        && !trig_en_q |=> state_q == ST_IDLE)
        else $error("pin edge started a measurement with trigger off");
    burst_strobe_c: cover property (mode_q == MODE_BURST
        && stb_q == STROBE_CYC);
    woc_hit_c: cover property (done_q && mode_q == MODE_WOC && hit);
    trig_go_c: cover property (trig_go ##[1:1000] state_q == ST_ACT);
endmodule

// [tb/mms_host_model.sv]
// Host-side model that issues commands over the link
module mms_host_model
    import mms_pkg::*;
(
    // Link clock from the bench
    input  wire logic link_clk,
    // Command link toward the sequencer
    output mms_cmd_t  link_cmd,
    output logic      link_cmd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        link_cmd = '0;
        link_cmd_valid = 1'b0;
    end

    // One-cycle pulse, then scrambled data so stale values never look valid
    task automatic send(input mms_op_t op, input logic [7:0] addr,
                        input logic [15:0] data);
        @(posedge link_clk);
        #1;
        link_cmd = '{op, addr, data};
        link_cmd_valid = 1'b1;
        @(posedge link_clk);
        #1;
        link_cmd_valid = 1'b0;
        link_cmd = ~link_cmd;
        // Spacing keeps one command from overrunning the crossing
        repeat (5) @(posedge link_clk);
    endtask
endmodule

// [tb/magnetometer_mode_sequencer_test.sv]
// Self-checking bench for the magnetometer mode sequencer
module magnetometer_mode_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    import mms_pkg::*;

    localparam int unsigned SET = 20;
    logic clk, rst_n, link_clk, link_cmd_valid, trig;
    logic interface_select_strap, addr_strap_low, addr_strap_high;
    logic ready_flag_pin_out, ready_flag_pin_oe, adc_start, adc_done;
    logic i2c_mode, serial_out_en;
    logic [1:0] adc_chan, i2c_addr_bits;
    logic [15:0] adc_value, level;
    logic [2:0] adc_wait = '0;
    wire ready_flag_pin_in;
    mms_cmd_t link_cmd;
    mms_status_t status;
    int mismatches = 0, checks = 0, cyc = 0, t_s0, t_s1, t_first;
    int n_set = 0, d;
    logic in_set = 1'b0;
    logic [1:0] chans[$];
    // Levels for the next set and flag expected after the current one;
    // the second half runs with the previous set as reference
    logic [15:0] level_tab[8] = '{16'h0100, 16'h0110, 16'h0111, 16'h0100,
                                 16'h010c, 16'h0118, 16'h012a, 16'h012a};
    logic flag_tab[8] = '{1'b0, 1'b0, 1'b0, 1'b1,
                          1'b0, 1'b0, 1'b0, 1'b1};

    // Pin level: device drives unless in trigger mode
    assign ready_flag_pin_in = ready_flag_pin_oe ? ready_flag_pin_out : trig;

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        link_clk = 1'b0;
        forever #7.5 link_clk = ~link_clk;
    end

    mms_host_model mms_host_model_i (.link_clk, .link_cmd, .link_cmd_valid);

    mms_seq #(.SETTLE_CYC(SET), .TICK_CYC(10)) mms_seq_i (
        .clk, .rst_n, .link_clk, .link_cmd_valid, .link_cmd,
        .interface_select_strap, .addr_strap_low, .addr_strap_high,
        .ready_flag_pin_in, .ready_flag_pin_out, .ready_flag_pin_oe,
        .adc_start, .adc_chan, .adc_done, .adc_value,
        .i2c_mode, .i2c_addr_bits, .serial_out_en, .status);

    // Converter answers four cycles after each start; value scrambled off
    assign adc_done = (adc_wait == 3'h1);
    assign adc_value = adc_done ? level : ~level;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (adc_start) begin
            if (chans.size() == 0)
                t_first <= cyc;
            chans.push_back(adc_chan);
            adc_wait <= 3'h4;
        end else if (adc_wait != 3'h0) begin
            adc_wait <= adc_wait - 3'h1;
        end
        // Settling window bounds and number of settling phases
        in_set <= (status.state == ST_SETTLE);
        if (status.state == ST_SETTLE) begin
            if (!in_set) begin
                t_s0 <= cyc;
                n_set <= n_set + 1;
            end
            t_s1 <= cyc;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic check(input string name, input logic [31:0] exp,
                         input logic [31:0] got);
        checks++;
        if (exp !== got) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic cmd(input mms_op_t op, input logic [7:0] a,
                       input logic [15:0] v);
        mms_host_model_i.send(op, a, v);
        tick(6);
    endtask

    task automatic wait_state(input mms_state_t st, input int lim);
        for (int n = 0; n < lim && status.state !== st; n++)
            tick(1);
        check("state", st, status.state);
    endtask

    task automatic wait_pin(input logic lv, input int lim);
        for (int n = 0; n < lim && ready_flag_pin_out !== lv; n++)
            tick(1);
        check("pin", lv, ready_flag_pin_out);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Watchdog sized well above the whole sequence
    initial begin
        repeat (40000) @(posedge clk);
        mismatches++;
        end_of_test();
    end

    initial begin
        {trig, rst_n, addr_strap_high} = 3'b000;
        {interface_select_strap, addr_strap_low} = 2'b11;
        level = 16'h0100;
        tick(12);
        rst_n = 1'b1;
        tick(8);
        check("oe", 1, ready_flag_pin_oe);
        check("out", 0, ready_flag_pin_out);
        check("mode", MODE_SINGLE, status.mode);
        check("idle", ST_IDLE, status.state);
        check("i2c", 1, i2c_mode);
        check("addr", 2'b01, i2c_addr_bits);
        check("sdo", 0, serial_out_en);
        // Second reset in mid-run with SPI straps
        {interface_select_strap, addr_strap_low, addr_strap_high} = 3'b001;
        rst_n = 1'b0;
        tick(12);
        rst_n = 1'b1;
        tick(8);
        check("i2c", 0, i2c_mode);
        check("addr", 2'b10, i2c_addr_bits);
        // Single set of Z, Y and temperature
        cmd(OP_WRITE, REG_CFG, 16'h000b);
        chans.delete();
        cmd(OP_SINGLE, 8'h00, 16'h0000);
        wait_state(ST_IDLE, 2000);
        wait_pin(1'b1, 10);
        check("settle", SET, t_s1 - t_s0 + 1);
        check("act", ACT_CYC, t_first - t_s1);
        check("n", 3, chans.size());
        check("order", 6'h07, {chans[0], chans[1], chans[2]});
        tick(100);
        check("hold", 1, ready_flag_pin_out);
        cmd(OP_READ, 8'h00, 16'h0000);
        check("read", 0, ready_flag_pin_out);
        // Trigger mode; second pulse during the set is ignored
        cmd(OP_WRITE, REG_CFG, 16'h0027);
        check("oe", 0, ready_flag_pin_oe);
        chans.delete();
        trig = 1'b1;
        tick(3);
        trig = 1'b0;
        tick(300);
        trig = 1'b1;
        tick(3);
        trig = 1'b0;
        wait_state(ST_IDLE, 2000);
        tick(20);
        check("trig", 3, chans.size());
        check("ready", 1, status.ready);
        cmd(OP_EXIT, 8'h00, 16'h0000);
        check("exit", 0, status.ready);
        // Burst at the slowest rate, host reads only after the strobe
        cmd(OP_WRITE, REG_CFG, 16'h0047);
        check("sdo", 1, serial_out_en);
        cmd(OP_WRITE, REG_RATE, 16'h007f);
        d = n_set;
        cmd(OP_BURST, 8'h00, 16'h0000);
        check("burst", MODE_BURST, status.mode);
        wait_pin(1'b1, 2000);
        check("first", d + 1, n_set);
        t_s0 = cyc;
        wait_state(ST_STANDBY_STATE, 10);
        wait_pin(1'b0, 2000);
        check("rate", 1, (cyc - t_s0) inside {[1250:1270]});
        d = cyc;
        wait_pin(1'b1, 1100);
        check("strobe", 1000, cyc - d);
        check("nosettle", t_s1 - t_s0 < 0, 1);
        cmd(OP_READ, 8'h00, 16'h0000);
        check("read", 0, ready_flag_pin_out);
        cmd(OP_SINGLE, 8'h00, 16'h0000);
        check("back", ST_IDLE, status.state);
        // Change wake on Z, reference fixed then previous set, threshold boundary
        cmd(OP_WRITE, REG_CFG, 16'h0041);
        cmd(OP_WRITE, REG_THR, 16'h0010);
        cmd(OP_WOC, 8'h00, 16'h0000);
        foreach (level_tab[i]) begin
            if (i == 4) begin
                cmd(OP_EXIT, 8'h00, 16'h0000);
                check("noref", 0, status.ref_valid);
                cmd(OP_WRITE, REG_CFG, 16'h0051);
                cmd(OP_WOC, 8'h00, 16'h0000);
            end
            wait_state(ST_WSLP, 3000);
            tick(4);
            check("woc", flag_tab[i], ready_flag_pin_out);
            check("ref", 1, status.ref_valid);
            level = level_tab[i];
            wait_state(ST_SETTLE, 3000);
        end
        cmd(OP_EXIT, 8'h00, 16'h0000);
        check("exit", ST_IDLE, status.state);
        check("clear", 0, ready_flag_pin_out);
        end_of_test();
    end

endmodule
